// [rtl/ibr_pkg.sv]
/*
  Constants, register map and types shared by the two-wire bit-rate and address block.
  Assumes a 32-bit AHB-Lite register bus and the rate table module beside it.
*/
package ibr_pkg;
  localparam int CNT_W = 14;
  localparam int TBL_W = 12;
  typedef logic [CNT_W-1:0] ibr_cnt_t;
  typedef logic [TBL_W-1:0] ibr_tbl_t;

  // register byte offsets
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // reset values and writable bits
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'hfe;
  localparam logic [7:0] CTRL_MASK = 8'h81;

  // field positions
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int RATE_MULTIPLIER_SELECT_MSB = 7;
  localparam int RATE_MULTIPLIER_SELECT_LSB = 6;
  localparam int RATE_MSB = 5;
  localparam int CTRL_EN = 7;
  localparam int CTRL_TEN = 0;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_WR = 2;
  localparam int CMD_RD = 3;
  localparam int CMD_DATA = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RX = 1;
  localparam int STAT_MATCH = 2;
  localparam int STAT_SCL = 3;
  localparam int STAT_SDA = 4;
  localparam int HTRANS_ACT = 1;

  // multiplier codes
  localparam logic [1:0] MUL_X1 = 2'h0;
  localparam logic [1:0] MUL_X2 = 2'h1;
  localparam logic [1:0] MUL_X4 = 2'h2;

  // address recognition
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // upper rate groups double the group eight codes below
  localparam logic [2:0] DERIV_GROUP = 3'h3;
  localparam logic [1:0] BASE_HI = 2'h3;
  localparam int DERIV_STEPS = 4;
  localparam ibr_tbl_t START_ADD = 12'h002;
  localparam ibr_tbl_t HOLD_SUB = 12'h001;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_STOP} ibr_state_t;
  typedef enum logic [1:0] {OP_WR, OP_RD, OP_STOP} ibr_op_t;
endpackage

// [rtl/ibr_rate_table.sv]
/*
  Combinational rate table: divider and three hold values for each 6-bit rate code.
  Assumes the caller scales the outputs by the multiplier factor.
*/
`timescale 1ns/10ps
module ibr_rate_table (
  input wire logic [5:0] code, // rate code
  output ibr_pkg::ibr_tbl_t divider, // clock divider
  output ibr_pkg::ibr_tbl_t sdaHold, // data hold value
  output ibr_pkg::ibr_tbl_t startHold, // start hold value
  output ibr_pkg::ibr_tbl_t stopHold // stop hold value
);
  logic [47:0] base;
  ibr_pkg::ibr_tbl_t d, h, s, p;
  wire [4:0] idx = code[5] ? {ibr_pkg::BASE_HI, code[2:0]} : code[4:0];
  wire [2:0] steps = code[5] ? code[5:3] - ibr_pkg::DERIV_GROUP : 3'h0;

  always_comb begin
    unique case (idx)
      5'h00: base = {12'h014, 12'h007, 12'h006, 12'h00b};
      5'h01: base = {12'h016, 12'h007, 12'h007, 12'h00c};
      5'h02: base = {12'h018, 12'h008, 12'h008, 12'h00d};
      5'h03: base = {12'h01a, 12'h008, 12'h009, 12'h00e};
      5'h04: base = {12'h01c, 12'h009, 12'h00a, 12'h00f};
      5'h05: base = {12'h01e, 12'h009, 12'h00b, 12'h010};
      5'h06: base = {12'h022, 12'h00a, 12'h00d, 12'h012};
      5'h07: base = {12'h028, 12'h00a, 12'h010, 12'h015};
      5'h08: base = {12'h01c, 12'h007, 12'h00a, 12'h00f};
      5'h09: base = {12'h020, 12'h007, 12'h00c, 12'h011};
      5'h0a: base = {12'h024, 12'h009, 12'h00e, 12'h013};
      5'h0b: base = {12'h028, 12'h009, 12'h010, 12'h015};
      5'h0c: base = {12'h02c, 12'h00b, 12'h012, 12'h017};
      5'h0d: base = {12'h030, 12'h00b, 12'h014, 12'h019};
      5'h0e: base = {12'h038, 12'h00d, 12'h018, 12'h01d};
      5'h0f: base = {12'h044, 12'h00d, 12'h01e, 12'h023};
      5'h10: base = {12'h030, 12'h009, 12'h012, 12'h019};
      5'h11: base = {12'h038, 12'h009, 12'h016, 12'h01d};
      5'h12: base = {12'h040, 12'h00d, 12'h01a, 12'h021};
      5'h13: base = {12'h048, 12'h00d, 12'h01e, 12'h025};
      5'h14: base = {12'h050, 12'h011, 12'h022, 12'h029};
      5'h15: base = {12'h058, 12'h011, 12'h026, 12'h02d};
      5'h16: base = {12'h068, 12'h015, 12'h02e, 12'h035};
      5'h17: base = {12'h080, 12'h015, 12'h03a, 12'h041};
      5'h18: base = {12'h050, 12'h009, 12'h026, 12'h029};
      5'h19: base = {12'h060, 12'h009, 12'h02e, 12'h031};
      5'h1a: base = {12'h070, 12'h011, 12'h036, 12'h039};
      5'h1b: base = {12'h080, 12'h011, 12'h03e, 12'h041};
      5'h1c: base = {12'h090, 12'h019, 12'h046, 12'h049};
      5'h1d: base = {12'h0a0, 12'h019, 12'h04e, 12'h051};
      5'h1e: base = {12'h0c0, 12'h021, 12'h05e, 12'h061};
      5'h1f: base = {12'h0f0, 12'h021, 12'h076, 12'h079};
    endcase
  end

  // codes from 0x20 repeat the last group, doubled once per group above it
  always_comb begin
    d = base[47:36];
    h = base[35:24];
    s = base[23:12];
    p = base[11:0];
    for (int k = 0; k < ibr_pkg::DERIV_STEPS; k++) begin
      if (3'(k) < steps) begin
        d = d << 1;
        h = (h << 1) - ibr_pkg::HOLD_SUB;
        s = (s << 1) + ibr_pkg::START_ADD;
        p = (p << 1) - ibr_pkg::HOLD_SUB;
      end
    end
  end

  assign divider = d;
  assign sdaHold = h;
  assign startHold = s;
  assign stopHold = p;
endmodule // ibr_rate_table

// [rtl/ibr_core.sv]
/*
  Two-wire bus bit-rate generator, own-address recognition and bit engine with AHB-Lite registers.
  Assumes one 10 MHz clock, open-drain pads outside resolving the wire levels,
  and a single AHB-Lite master performing word transfers.
*/
`timescale 1ns/10ps
// Behaviour
// - Clock line is open drain both ways: driven low when clocking, sensed always.
// - Data line is open drain both ways: address, data and acknowledge bits.
// - Own address sits in bits 7..1 and is matched against bus addresses.
// - Same field is the whole 7-bit address or low seven 10-bit bits.
// - Multiplier code 00, 01, 10 gives factor 1, 2, 4; 11 reserved.
// - Six-bit rate code selects divider, data hold, start hold, stop hold.
// - Master clock period is bus period times multiplier times divider.
// - Data changes multiplier times data hold cycles after clock falls.
// - Start: clock stays high multiplier times start hold after data falls.
// - Stop: data released multiplier times stop hold after clock rises.
// - Code 0x00 gives 20, 7, 6, 11; codes to 0x07 follow table.
// - Code 0x17 gives 128, 21, 58, 65; rest to 0x1F per table.
// - Code 0x1F gives 240, 33, 118, 121.
// - Codes 0x20 to 0x3F continue; 0x3F gives 3840, 513, 1918, 1921.
// - Control bit 7 enables the block; zero disables it.
module ibr_core (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // asynchronous reset, low active
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic sclIn, // clock wire level
  output logic sclOut, // clock drive value
  output logic sclOe, // clock pull-low enable
  input wire logic sdaIn, // data wire level
  output logic sdaOut, // data drive value
  output logic sdaOe, // data pull-low enable
  output logic addrMatch // own address seen
);
  logic [7:0] ownSlaveAddress_ff, bitRateDivider_ff, control_ff, statusVal;
  logic wrPend_ff, rxBit_ff, addrMatch_ff, sclOe_ff, sdaOe_ff, hrespOk_ff, ready_ff;
  logic [7:0] wrOfs_ff;
  logic [31:0] hrdata_ff;
  logic sclMeta_ff, sclSync_ff, sclPrev_ff, sdaMeta_ff, sdaSync_ff, sdaPrev_ff;
  logic snoopAct_ff, tenPend_ff, dataBit_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff;
  ibr_pkg::ibr_state_t state_ff, nxt_state;
  ibr_pkg::ibr_op_t op_ff, nxt_op;
  ibr_pkg::ibr_cnt_t cnt_ff, nxt_cnt, age_ff;
  logic nxt_sclOe, nxt_sdaOe, nxt_rxBit, nxt_dataBit;
  ibr_pkg::ibr_tbl_t divBase, sdaBase, startBase, stopBase;

  function automatic ibr_pkg::ibr_cnt_t scaleCnt(input ibr_pkg::ibr_tbl_t v,
                                                 input logic [1:0] m);
    ibr_pkg::ibr_cnt_t w;
    w = ibr_pkg::ibr_cnt_t'(v);
    case (m)
      ibr_pkg::MUL_X2: scaleCnt = w << 1;
      ibr_pkg::MUL_X4: scaleCnt = w << 2;
      default: scaleCnt = w;
    endcase
  endfunction

  // register bus: zero wait state, read data captured in the address phase
  wire addrPhase = hsel && htrans[ibr_pkg::HTRANS_ACT] && hready;
  wire [7:0] busOfs = haddr[7:0];
  wire wrAddrReg = wrPend_ff && (wrOfs_ff == ibr_pkg::OFS_ADDR);
  wire wrRateReg = wrPend_ff && (wrOfs_ff == ibr_pkg::OFS_RATE);
  wire wrCtrlReg = wrPend_ff && (wrOfs_ff == ibr_pkg::OFS_CTRL);
  wire wrCmdReg = wrPend_ff && (wrOfs_ff == ibr_pkg::OFS_CMD);
  wire wrStatReg = wrPend_ff && (wrOfs_ff == ibr_pkg::OFS_STAT);
  wire enable = control_ff[ibr_pkg::CTRL_EN];
  wire tenBit = control_ff[ibr_pkg::CTRL_TEN];
  wire busy = (state_ff != ibr_pkg::ST_IDLE);
  wire [7:0] rdByte = (busOfs == ibr_pkg::OFS_ADDR) ? ownSlaveAddress_ff :
                      (busOfs == ibr_pkg::OFS_RATE) ? bitRateDivider_ff :
                      (busOfs == ibr_pkg::OFS_CTRL) ? control_ff :
                      (busOfs == ibr_pkg::OFS_STAT) ? statusVal : 8'h00;

  always_comb begin
    statusVal = 8'h00;
    statusVal[ibr_pkg::STAT_BUSY] = busy;
    statusVal[ibr_pkg::STAT_RX] = rxBit_ff;
    statusVal[ibr_pkg::STAT_MATCH] = addrMatch_ff;
    statusVal[ibr_pkg::STAT_SCL] = sclSync_ff;
    statusVal[ibr_pkg::STAT_SDA] = sdaSync_ff;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPend_ff <= 1'b0;
      wrOfs_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      wrPend_ff <= addrPhase && hwrite;
      if (addrPhase) begin
        wrOfs_ff <= busOfs;
        if (!hwrite) begin
          hrdata_ff <= {24'h000000, rdByte};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ownSlaveAddress_ff <= ibr_pkg::RST_ADDR;
      bitRateDivider_ff <= ibr_pkg::RST_RATE;
      control_ff <= ibr_pkg::RST_CTRL;
    end else begin
      if (wrAddrReg) ownSlaveAddress_ff <= hwdata[7:0] & ibr_pkg::ADDR_MASK;
      if (wrRateReg) bitRateDivider_ff <= hwdata[7:0];
      if (wrCtrlReg) control_ff <= hwdata[7:0] & ibr_pkg::CTRL_MASK;
    end
  end

  // rate selection and scaled counts
  wire [1:0] mulCode = bitRateDivider_ff[ibr_pkg::RATE_MULTIPLIER_SELECT_MSB:ibr_pkg::RATE_MULTIPLIER_SELECT_LSB];
  wire [5:0] rateCode = bitRateDivider_ff[ibr_pkg::RATE_MSB:0];

  ibr_rate_table u_table (
    .code(rateCode),
    .divider(divBase),
    .sdaHold(sdaBase),
    .startHold(startBase),
    .stopHold(stopBase)
  );

  wire ibr_pkg::ibr_cnt_t sclPeriod = scaleCnt(divBase, mulCode);
  wire ibr_pkg::ibr_cnt_t lowCnt = sclPeriod >> 1;
  wire ibr_pkg::ibr_cnt_t highCnt = sclPeriod - lowCnt;
  wire ibr_pkg::ibr_cnt_t sdaHoldCnt = scaleCnt(sdaBase, mulCode);
  wire ibr_pkg::ibr_cnt_t startCnt = scaleCnt(startBase, mulCode);
  wire ibr_pkg::ibr_cnt_t stopCnt = scaleCnt(stopBase, mulCode);

  // commands are taken only while enabled and idle
  wire cmdOk = wrCmdReg && enable && !busy;
  wire cmdStart = cmdOk && hwdata[ibr_pkg::CMD_START];
  wire cmdStop = cmdOk && hwdata[ibr_pkg::CMD_STOP];
  wire cmdBit = cmdOk && (hwdata[ibr_pkg::CMD_WR] || hwdata[ibr_pkg::CMD_RD]);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 1'b1;
    nxt_sclOe = sclOe_ff;
    nxt_sdaOe = sdaOe_ff;
    nxt_rxBit = rxBit_ff;
    nxt_op = op_ff;
    nxt_dataBit = dataBit_ff;
    if (!enable) begin
      nxt_state = ibr_pkg::ST_IDLE;
      nxt_cnt = '0;
      nxt_sclOe = 1'b0;
      nxt_sdaOe = 1'b0;
    end else begin
      unique case (state_ff)
        ibr_pkg::ST_IDLE: begin
          nxt_cnt = '0;
          if (cmdStart) begin
            if (sclSync_ff && sdaSync_ff) begin
              nxt_state = ibr_pkg::ST_START;
              nxt_sdaOe = 1'b1;
            end
          end else if (cmdStop || cmdBit) begin
            nxt_state = ibr_pkg::ST_LOW;
            nxt_sclOe = 1'b1;
            nxt_op = cmdStop ? ibr_pkg::OP_STOP :
                     hwdata[ibr_pkg::CMD_WR] ? ibr_pkg::OP_WR : ibr_pkg::OP_RD;
            nxt_dataBit = hwdata[ibr_pkg::CMD_DATA];
          end
        end
        ibr_pkg::ST_START: begin
          if (cnt_ff == startCnt - 1'b1) begin
            nxt_sclOe = 1'b1;
            nxt_state = ibr_pkg::ST_IDLE;
            nxt_cnt = '0;
          end
        end
        ibr_pkg::ST_LOW: begin
          if (cnt_ff == sdaHoldCnt - 1'b1) begin
            nxt_sdaOe = (op_ff == ibr_pkg::OP_STOP) ||
                        ((op_ff == ibr_pkg::OP_WR) && !dataBit_ff);
          end
          if (cnt_ff == lowCnt - 1'b1) begin
            nxt_sclOe = 1'b0;
            nxt_state = ibr_pkg::ST_HIGH;
            nxt_cnt = '0;
          end
        end
        ibr_pkg::ST_HIGH: begin
          if (!sclSync_ff) begin
            nxt_cnt = cnt_ff;
          end else if (op_ff == ibr_pkg::OP_STOP) begin
            nxt_state = ibr_pkg::ST_STOP;
            nxt_cnt = '0;
          end else if (cnt_ff == highCnt - 1'b1) begin
            nxt_rxBit = sdaSync_ff;
            nxt_sclOe = 1'b1;
            nxt_state = ibr_pkg::ST_IDLE;
            nxt_cnt = '0;
          end
        end
        ibr_pkg::ST_STOP: begin
          if (cnt_ff == stopCnt - 1'b1) begin
            nxt_sdaOe = 1'b0;
            nxt_state = ibr_pkg::ST_IDLE;
            nxt_cnt = '0;
          end
        end
        default: begin
          nxt_state = ibr_pkg::ST_IDLE;
          nxt_cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ibr_pkg::ST_IDLE;
      cnt_ff <= '0;
      op_ff <= ibr_pkg::OP_WR;
      dataBit_ff <= 1'b0;
      sclOe_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
      rxBit_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
      dataBit_ff <= nxt_dataBit;
      sclOe_ff <= nxt_sclOe;
      sdaOe_ff <= nxt_sdaOe;
      rxBit_ff <= nxt_rxBit;
    end
  end

  // pin synchronisers, plus one more stage for edge detection
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {sclMeta_ff, sclSync_ff, sclPrev_ff} <= 3'h7;
      {sdaMeta_ff, sdaSync_ff, sdaPrev_ff} <= 3'h7;
    end else begin
      {sclMeta_ff, sclSync_ff, sclPrev_ff} <= {sclIn, sclMeta_ff, sclSync_ff};
      {sdaMeta_ff, sdaSync_ff, sdaPrev_ff} <= {sdaIn, sdaMeta_ff, sdaSync_ff};
    end
  end

  // address snooping: first byte after a start, or second byte in 10-bit mode
  wire startSeen = sclSync_ff && sclPrev_ff && sdaPrev_ff && !sdaSync_ff;
  wire stopSeen = sclSync_ff && sclPrev_ff && !sdaPrev_ff && sdaSync_ff;
  wire sclRise = sclSync_ff && !sclPrev_ff;
  wire [7:0] nxtShift = {shift_ff[6:0], sdaSync_ff};
  wire byteDone = snoopAct_ff && sclRise && (bitCnt_ff == ibr_pkg::BYTE_BITS - 1'b1);
  wire [6:0] ownField = ownSlaveAddress_ff[ibr_pkg::ADDR_MSB:ibr_pkg::ADDR_LSB];
  wire tenHdr = tenBit && !tenPend_ff && (nxtShift[7:3] == ibr_pkg::TEN_BIT_HDR);
  wire match7 = !tenBit && (nxtShift[7:1] == ownField);
  wire match10 = tenBit && tenPend_ff && (nxtShift[6:0] == ownField);
  wire hitPulse = byteDone && (match7 || match10);
  wire clrMatch = wrStatReg && hwdata[ibr_pkg::STAT_MATCH];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      snoopAct_ff <= 1'b0;
      tenPend_ff <= 1'b0;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      addrMatch_ff <= 1'b0;
    end else begin
      addrMatch_ff <= enable && (hitPulse || (addrMatch_ff && !clrMatch));
      if (!enable || stopSeen) begin
        snoopAct_ff <= 1'b0;
      end else if (startSeen) begin
        snoopAct_ff <= 1'b1;
        tenPend_ff <= 1'b0;
        bitCnt_ff <= 4'h0;
      end else if (snoopAct_ff && sclRise) begin
        shift_ff <= nxtShift;
        bitCnt_ff <= (bitCnt_ff == ibr_pkg::BYTE_BITS) ? 4'h0 : bitCnt_ff + 1'b1;
        if (byteDone) begin
          tenPend_ff <= tenHdr;
          snoopAct_ff <= tenHdr;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hrespOk_ff <= 1'b0;
      ready_ff <= 1'b1;
    end else begin
      hrespOk_ff <= 1'b0;
      ready_ff <= 1'b1;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = ready_ff;
  assign hresp = hrespOk_ff;
  assign sclOut = hrespOk_ff;
  assign sdaOut = hrespOk_ff;
  assign sclOe = sclOe_ff;
  assign sdaOe = sdaOe_ff;
  assign addrMatch = addrMatch_ff;

  // cycles since either line drive last changed
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      age_ff <= '0;
    end else begin
      age_ff <= ((nxt_sclOe != sclOe_ff) || (nxt_sdaOe != sdaOe_ff)) ? '0 : age_ff + 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence startEnd_s;
    $rose(sclOe_ff) && $past(state_ff) == ibr_pkg::ST_START;
  endsequence
  sequence highEnd_s;
    $rose(sclOe_ff) && $past(state_ff) == ibr_pkg::ST_HIGH;
  endsequence

  disable_release_a: assert property (!enable |=> !sclOe_ff && !sdaOe_ff && !busy)
    else $error("lines not released after disable");
  start_hold_a: assert property (startEnd_s |-> $past(age_ff) == startCnt - 1'b1)
    else $error("start hold count wrong");
  sda_hold_a: assert property ($changed(sdaOe_ff) && $past(state_ff) == ibr_pkg::ST_LOW
    && $past(enable) |-> $past(cnt_ff) == sdaHoldCnt - 1'b1 && sclOe_ff)
    else $error("data changed outside hold point");
  stop_hold_a: assert property ($fell(sdaOe_ff) && $past(state_ff) == ibr_pkg::ST_STOP
    && $past(enable) |-> $past(cnt_ff) == stopCnt - 1'b1 && !sclOe_ff)
    else $error("stop hold count wrong");
  low_time_a: assert property ($fell(sclOe_ff) && $past(enable)
    |-> $past(cnt_ff) == lowCnt - 1'b1)
    else $error("clock low time wrong");
  high_time_a: assert property (highEnd_s |-> $past(cnt_ff) == highCnt - 1'b1
    && rxBit_ff == $past(sdaSync_ff))
    else $error("clock high time or sample wrong");
  stretch_a: assert property (state_ff == ibr_pkg::ST_HIGH && !sclSync_ff && enable
    |=> cnt_ff == $past(cnt_ff) && !sclOe_ff)
    else $error("counter ran while clock held low");
  mul_sel_a: assert property (mulCode == ibr_pkg::MUL_X4
    |-> sclPeriod == (ibr_pkg::ibr_cnt_t'(divBase) << 2))
    else $error("multiplier four not applied");
  table_ends_a: assert property (rateCode == 6'h3f |-> divBase == 12'hf00
    && sdaBase == 12'h201 && startBase == 12'h77e && stopBase == 12'h781)
    else $error("top rate code entry wrong");
  table_mid_a: assert property (rateCode == 6'h17 |-> divBase == 12'h080
    && startBase == 12'h03a && stopBase == 12'h041)
    else $error("rate code 0x17 entry wrong");
  match_set_a: assert property ($rose(addrMatch_ff) |-> $past(byteDone)
    && ($past(nxtShift[7:1]) == ownField || $past(tenPend_ff)))
    else $error("address match without own address");
  ten_match_a: assert property ($rose(addrMatch_ff) && $past(tenPend_ff)
    |-> $past(nxtShift[6:0]) == ownField)
    else $error("10-bit low address mismatch");
endmodule // ibr_core

// [testbench/ibr_bus_partner.sv]
/*
  Other party on the two-wire bus: pull-ups, a master that sends frames, clock stretching.
  Assumes the design's open-drain enables and one shared system clock.
*/
`timescale 1ns/10ps
module ibr_bus_partner (
  input wire logic clk_sys, // system clock
  input wire logic sclOe, // design pulls clock low
  input wire logic sdaOe, // design pulls data low
  output logic sclIn, // clock wire level
  output logic sdaIn // data wire level
);
  logic pScl = 1'b0;
  logic pSda = 1'b0;
  int stretch = 5;
  // released wires float high through the pull-ups
  assign sclIn = !(sclOe | pScl);
  assign sdaIn = !(sdaOe | pSda);
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // slow slave holds the clock low for stretch cycles each time the design releases it
  always @(negedge sclOe) begin
    if (stretch > 0) begin
      pScl <= 1'b1;
      hold(stretch);
      pScl <= 1'b0;
    end
  end
  task automatic bitOut(input logic v);
    pSda <= !v;
    hold(30);
    pScl <= 1'b0;
    hold(30);
    pScl <= 1'b1;
  endtask
  // start, nb bytes with a released acknowledge slot, stop
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int nb);
    logic [7:0] b;
    hold(1);
    pSda <= 1'b1;
    hold(30);
    pScl <= 1'b1;
    for (int j = 0; j < nb; j++) begin
      b = (j == 0) ? b0 : b1;
      for (int i = 7; i >= 0; i--) bitOut(b[i]);
      bitOut(1'b1);
    end
    pSda <= 1'b1;
    hold(30);
    pScl <= 1'b0;
    hold(30);
    pSda <= 1'b0;
  endtask
endmodule // ibr_bus_partner

// [testbench/testbench.sv]
/*
  Self-checking bench: AHB-Lite master, rate and hold timing, address recognition.
  Assumes ibr_core with zero-wait AHB-Lite slave and the two-wire partner model.
*/
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seenV, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe, addrMatch;
  logic [7:0] own;
  logic [31:0] expQ[$];
  event resEv;
  int error_cnt = 0, tests_run = 0, tS, tC, m, f;
  int codes[5] = '{0, 'h7, 'h17, 'h1f, 'h3f}, muls[5] = '{0, 1, 2, 0, 0};
  int divs[5] = '{20, 40, 128, 240, 3840}, sdas[5] = '{7, 10, 21, 33, 513};
  int sts[5] = '{6, 16, 58, 118, 1918}, sps[5] = '{11, 21, 65, 121, 1921};
  assign hready = hreadyout;
  always #50 clk_sys = ~clk_sys;
  ibr_core dut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclIn(sclIn), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrMatch(addrMatch));
  ibr_bus_partner partner (.clk_sys(clk_sys), .sclOe(sclOe), .sdaOe(sdaOe), .sclIn(sclIn),
    .sdaIn(sdaIn));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // watcher pairs each result with the oldest expectation
  always begin
    @(resEv);
    check(seenV, expQ.pop_front());
  end
  task automatic expect_v(input logic [31:0] s, input logic [31:0] e);
    seenV = s;
    expQ.push_back(e);
    ->resEv;
    #1;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic waitIdle();
    do xfer(1'b0, ibr_pkg::OFS_STAT, 32'h0); while (r[ibr_pkg::STAT_BUSY] !== 1'b0);
  endtask
  // command, then edges until the clock enable changes, and the data enable too when needS is set
  task automatic cmd(input logic [7:0] c, input logic needS);
    logic s0, c0;
    xfer(1'b1, ibr_pkg::OFS_CMD, {24'h0, c});
    @(negedge clk_sys);
    s0 = sdaOe;
    c0 = sclOe;
    tS = -1;
    tC = -1;
    for (int n = 1; n < 8000 && (tC < 0 || (needS && tS < 0)); n++) begin
      @(negedge clk_sys);
      if (tS < 0 && sdaOe !== s0) tS = n;
      if (tC < 0 && sclOe !== c0) tC = n;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #5000000;
    error_cnt++;
    summarize();
  end
  initial begin
    void'($urandom(42));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (codes[i]) begin
      xfer(1'b0, 8'h04 * i[7:0], 32'h0);
      expect_v(r, (i == 4) ? 32'h18 : 32'h0);
    end
    expect_v({hreadyout, hresp, sclOut, sdaOut}, 32'h8);
    cmd(8'h01, 1'b0);
    expect_v(sdaOe, 32'h0);
    own = 8'($urandom);
    xfer(1'b1, ibr_pkg::OFS_ADDR, {24'h0, own});
    xfer(1'b0, ibr_pkg::OFS_ADDR, 32'h0);
    expect_v(r, {24'h0, own & ibr_pkg::ADDR_MASK});
    xfer(1'b1, ibr_pkg::OFS_CTRL, 32'h80);
    foreach (codes[i]) begin
      f = 1 << muls[i];
      xfer(1'b1, ibr_pkg::OFS_RATE, 32'(muls[i] * 64 + codes[i]));
      xfer(1'b0, ibr_pkg::OFS_RATE, 32'h0);
      expect_v(r, 32'(muls[i] * 64 + codes[i]));
      cmd(8'h01, 1'b0);
      expect_v(tC, f * sts[i]);
      waitIdle();
      cmd((i % 2) ? 8'h08 : 8'h14, 1'b1);
      expect_v(tS, f * sdas[i]);
      expect_v(tC, (f * divs[i]) / 2);
      waitIdle();
      expect_v(r[ibr_pkg::STAT_RX], 32'h1);
      if (i == 0) begin
        cmd(8'h04, 1'b1);
        expect_v(tS, f * sdas[i]);
        waitIdle();
        expect_v(r[ibr_pkg::STAT_RX], 32'h0);
      end
      cmd(8'h02, 1'b0);
      while (sclIn !== 1'b1) @(negedge clk_sys);
      for (m = 0; m < 20000 && sdaOe !== 1'b0; m++) @(negedge clk_sys);
      expect_v(m >= f * sps[i] && m <= f * sps[i] + 4, 32'h1);
      waitIdle();
    end
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, ibr_pkg::OFS_CTRL, (k == 2) ? 32'h81 : 32'h80);
      partner.frame((k == 2) ? 8'hf0 : ((own & 8'hfe) ^ ((k == 1) ? 8'h02 : 8'h00)),
        {1'b0, own[7:1]}, (k == 2) ? 2 : 1);
      expect_v(addrMatch, (k != 1));
      xfer(1'b0, ibr_pkg::OFS_STAT, 32'h0);
      expect_v(r[ibr_pkg::STAT_MATCH], (k != 1));
      xfer(1'b1, ibr_pkg::OFS_STAT, 32'h4);
    end
    summarize();
  end
endmodule // testbench
